// ===== src/wwd_map.vh
`ifndef WWD_MAP_VH
`define WWD_MAP_VH

// register byte offsets
`define WWD_OFS_CTRL 10'h000
`define WWD_OFS_CLEAR 10'h004
`define WWD_OFS_STATUS 10'h008
`define WWD_OFS_VERSION 10'h3fc

// key field and values
`define WWD_KEY_HI 31
`define WWD_KEY_LO 24
`define WWD_KEY_FIRST 8'h55
`define WWD_KEY_SECOND 8'haa

// control field positions
`define WWD_CTRL_EN 0
`define WWD_CTRL_DAR 1
`define WWD_CTRL_MODE 2
`define WWD_CTRL_LOCK 3
`define WWD_CTRL_FCD 7
`define WWD_CTRL_PSEL_LO 8
`define WWD_CTRL_PSEL_HI 12
`define WWD_CTRL_CEN 16
`define WWD_CTRL_SRC 17
`define WWD_CTRL_TBAN_LO 18
`define WWD_CTRL_TBAN_HI 22

// clear and status field positions
`define WWD_CLR_CMD 0
`define WWD_SR_WINDOW 0
`define WWD_SR_CLEARED 1

// reset values
`define WWD_RST_PSEL 5'h00
`define WWD_RST_TBAN 5'h00
`define WWD_FUSE_PSEL 5'h10
`define WWD_RST_STATUS 2'h3

// timing counts in hclk cycles
`define WWD_CLR_SYNC_CYCLES 2'h2
`define WWD_BOOT_CYCLES 2'h3

`endif

// ===== src/wwd_sync.v
`timescale 1ns/1ps
// two-stage synchroniser, one per bit
module wwd_sync #(
  parameter WIDTH = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ===== src/wwd_count.v
`timescale 1ns/1ps
// watchdog counter with ban and timeout limits
module wwd_count #(
  parameter CW = 32
) (
  input wire hclk,
  input wire hresetn,
  input wire tick,
  input wire clear,
  input wire mode,
  input wire [4:0] psel,
  input wire [4:0] tban,
  output reg [CW+1:0] count,
  output wire in_window,
  output reg expire
);
  localparam [CW+1:0] ONE = 1;
  wire [5:0] psel_sh;
  wire [5:0] tban_sh;
  wire [CW+1:0] psel_len;
  wire [CW+1:0] ban_len;
  wire [CW+1:0] limit;
  wire [CW+1:0] count_inc;

  // period lengths are 2^(field+1) counter ticks
  assign psel_sh = {1'b0, psel} + 6'h01;
  assign tban_sh = {1'b0, tban} + 6'h01;
  assign psel_len = ONE << psel_sh;
  assign ban_len = ONE << tban_sh;
  assign limit = mode ? (ban_len + psel_len) : psel_len;
  assign count_inc = count + ONE;
  assign in_window = !mode || (count >= ban_len);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= {(CW+2){1'b0}};
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (clear) begin
        count <= {(CW+2){1'b0}};
      end else if (tick) begin
        if (count_inc >= limit) begin
          count <= {(CW+2){1'b0}};
          expire <= 1'b1;
        end else begin
          count <= count_inc;
        end
      end
    end
  end
endmodule

// ===== src/wwd_top.v
// Contract
// - control write needs key 0x55 then 0xAA with identical other bits.
// - clear needs key 0x55 with clear bit, then 0xAA with clear bit.
// - non-watchdog reset enables counter clock with system RC source.
// - basic mode timeout is 2^(psel+1) counter clock periods.
// - enable readback changes only after synchronisation completes; code clears it at once on watchdog reset with disable-after-reset set.
// - counter cleared by valid clear, keyed control write, or timeout.
// - clear request drops cleared flag; flag returns when clear done.
// - basic mode: missed clear gives watchdog reset at period end.
// - disable-after-reset zero keeps timer enabled, restarting from zero.
// - disable-after-reset one: watchdog reset clears only enable; code clears lock bit too.
// - fuse auto-enable with calibration flag zero blocks setting disable-after-reset.
// - mode bit selects window; changeable only while disabled.
// - window timeout is ban plus psel; clear in ban resets.
// - clear in window period restarts counter into ban period.
// - any control change clears counter without watchdog reset.
// - software disables via enable only; stopped clock blocks readback zero.
// - fuse start: basic mode, RC source, timeout above 100 ms.
// - calibration flag decides recalibration or config keep at watchdog reset.
// - lock bit ignores control writes until any reset.
// - enabled timer limits sleep depth to keep its source running.
// - debug freezes counter unless run-in-debug and peripheral debug set.
// - source select zero is system RC, one is 32 kHz crystal.
// - window flag zero in ban period, one in timeout period.
`timescale 1ns/1ps
`include "wwd_map.vh"
module wwd_top #(
  parameter CW = 32,
  parameter SLEEP_W = 3,
  parameter [SLEEP_W-1:0] RC_DEEPEST = 3'h4,
  parameter [SLEEP_W-1:0] XTAL_DEEPEST = 3'h6,
  // arbitrary identification value
  parameter [31:0] VERSION_ID = 32'h00000100
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire system_rc_osc,
  input wire crystal_32k_osc,
  input wire auto_enable_fuse,
  input wire calibration_done,
  input wire debug_halt,
  input wire run_in_debug,
  input wire peripheral_debug_en,
  input wire [SLEEP_W-1:0] sleep_req,
  output wire [SLEEP_W-1:0] sleep_grant,
  output reg watchdog_reset,
  output reg calibration_start
);
  reg dp_valid;
  reg dp_write;
  reg [9:0] dp_addr;
  // control fields
  reg en;
  reg en_ack;
  reg disable_after_reset;
  reg mode;
  reg config_lock;
  reg calibration_done_flag;
  reg [4:0] psel;
  reg count_clock_enable;
  reg cen_ack;
  reg source_select;
  reg [4:0] tban;
  // key sequencing
  reg ctrl_pend;
  reg [23:0] ctrl_first;
  reg clr_pend;
  // clear handshake
  reg cleared;
  reg [1:0] clr_wait;
  reg clr_done;
  // boot sequencing and source edge history
  reg [1:0] boot_cnt;
  reg boot_done;
  reg fuse_applied;
  reg src_prev;

  wire [1:0] osc_sync;
  wire fuse_sync;
  wire src_lvl;
  wire src_edge;
  wire freeze;
  wire tick;
  wire in_window;
  wire expire;
  wire [CW+1:0] count;
  wire wr;
  wire [7:0] key;
  wire ctrl_wr;
  wire clr_wr;
  wire ctrl_commit;
  wire clr_valid;
  wire ban_violation;
  wire wd_fire;
  wire counter_clear;
  wire [31:0] ctrl_view;
  wire [SLEEP_W-1:0] deepest;

  // zero wait states, response always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  wwd_sync #(
    .WIDTH(3)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({auto_enable_fuse, crystal_32k_osc, system_rc_osc}),
    .sync_out({fuse_sync, osc_sync})
  );

  assign src_lvl = source_select ? osc_sync[1] : osc_sync[0];
  // one tick per rising edge of the synchronised source
  assign src_edge = src_lvl && !src_prev;
  assign freeze = debug_halt && !(run_in_debug && peripheral_debug_en);
  assign tick = src_edge && cen_ack && en_ack && !freeze;

  wwd_count #(
    .CW(CW)
  ) u_count (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .clear(counter_clear),
    .mode(mode),
    .psel(psel),
    .tban(tban),
    .count(count),
    .in_window(in_window),
    .expire(expire)
  );

  // address phase capture; slave never stretches
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 10'h000;
    end else if (hready) begin
      dp_valid <= hsel && htrans[1];
      dp_write <= hwrite;
      dp_addr <= haddr[9:0];
    end
  end

  assign wr = dp_valid && dp_write;
  assign key = hwdata[`WWD_KEY_HI:`WWD_KEY_LO];
  assign ctrl_wr = wr && (dp_addr == `WWD_OFS_CTRL);
  assign clr_wr = wr && (dp_addr == `WWD_OFS_CLEAR);
  // second key must match first bits
  assign ctrl_commit = ctrl_wr && ctrl_pend && (key == `WWD_KEY_SECOND)
    && (hwdata[23:0] == ctrl_first) && !config_lock;
  assign clr_valid = clr_wr && clr_pend && (key == `WWD_KEY_SECOND)
    && hwdata[`WWD_CLR_CMD];

  assign ban_violation = clr_valid && cleared && en_ack && !in_window;
  assign wd_fire = (expire && en_ack) || ban_violation;
  assign counter_clear = clr_done || ctrl_commit || wd_fire;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_pend <= 1'b0;
      ctrl_first <= 24'h000000;
      clr_pend <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_pend <= (key == `WWD_KEY_FIRST);
        ctrl_first <= hwdata[23:0];
      end
      if (clr_wr) begin
        clr_pend <= (key == `WWD_KEY_FIRST) && hwdata[`WWD_CLR_CMD];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cleared <= 1'b1;
      clr_wait <= 2'h0;
      clr_done <= 1'b0;
    end else begin
      clr_done <= 1'b0;
      if (clr_wait != 2'h0) begin
        clr_wait <= clr_wait - 2'h1;
        if (clr_wait == 2'h1) begin
          clr_done <= 1'b1;
          cleared <= 1'b1;
        end
      end else if (clr_valid && cleared && !ban_violation) begin
        cleared <= 1'b0;
        clr_wait <= `WWD_CLR_SYNC_CYCLES;
      end
    end
  end

  // boot sequencing: fuse sampled once the synchroniser has settled
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_cnt <= 2'h0;
      boot_done <= 1'b0;
    end else if (!boot_done) begin
      boot_cnt <= boot_cnt + 2'h1;
      if (boot_cnt == `WWD_BOOT_CYCLES) begin
        boot_done <= 1'b1;
      end
    end
  end

  // control register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en <= 1'b0;
      disable_after_reset <= 1'b0;
      mode <= 1'b0;
      config_lock <= 1'b0;
      calibration_done_flag <= 1'b0;
      psel <= `WWD_RST_PSEL;
      count_clock_enable <= 1'b1;
      source_select <= 1'b0;
      tban <= `WWD_RST_TBAN;
      fuse_applied <= 1'b0;
      calibration_start <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      calibration_start <= 1'b0;
      watchdog_reset <= wd_fire;
      if (calibration_done) begin
        calibration_done_flag <= 1'b1;
      end
      if (boot_done && !fuse_applied) begin
        fuse_applied <= 1'b1;
        calibration_start <= 1'b1;
        if (fuse_sync) begin
          en <= 1'b1;
          mode <= 1'b0;
          source_select <= 1'b0;
          count_clock_enable <= 1'b1;
          psel <= `WWD_FUSE_PSEL;
        end
      end else if (wd_fire) begin
        config_lock <= 1'b0;
        if (disable_after_reset) begin
          en <= 1'b0;
        end
        // recalibrate when flag low, else keep config
        if (!calibration_done_flag) begin
          calibration_start <= 1'b1;
          if (fuse_sync) begin
            en <= 1'b1;
          end
        end
      end else if (ctrl_commit) begin
        en <= ctrl_first[`WWD_CTRL_EN];
        if (!(fuse_sync && !calibration_done_flag && ctrl_first[`WWD_CTRL_DAR])) begin
          disable_after_reset <= ctrl_first[`WWD_CTRL_DAR];
        end
        if (!en && !en_ack) begin
          mode <= ctrl_first[`WWD_CTRL_MODE];
        end
        config_lock <= ctrl_first[`WWD_CTRL_LOCK];
        if (ctrl_first[`WWD_CTRL_FCD]) begin
          calibration_done_flag <= 1'b1;
        end
        psel <= ctrl_first[`WWD_CTRL_PSEL_HI:`WWD_CTRL_PSEL_LO];
        count_clock_enable <= ctrl_first[`WWD_CTRL_CEN];
        source_select <= ctrl_first[`WWD_CTRL_SRC];
        tban <= ctrl_first[`WWD_CTRL_TBAN_HI:`WWD_CTRL_TBAN_LO];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev <= 1'b0;
      cen_ack <= 1'b1;
      en_ack <= 1'b0;
    end else begin
      src_prev <= src_lvl;
      if (wd_fire && disable_after_reset) begin
        // without disable the timer keeps running
        en_ack <= 1'b0;
      end else if (src_edge) begin
        cen_ack <= count_clock_enable;
        if (cen_ack) begin
          en_ack <= en;
        end
      end
    end
  end

  assign deepest = source_select ? XTAL_DEEPEST : RC_DEEPEST;
  assign sleep_grant = (en_ack && (sleep_req > deepest)) ? deepest : sleep_req;

  // key field always reads as zero
  assign ctrl_view = {8'h00, 1'b0, tban, source_select, cen_ack, 3'h0, psel,
    calibration_done_flag, 3'h0, config_lock, mode, disable_after_reset, en_ack};

  // read data registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[9:0])
        `WWD_OFS_CTRL: hrdata <= ctrl_view;
        `WWD_OFS_STATUS: hrdata <= {30'h00000000, cleared, in_window};
        `WWD_OFS_VERSION: hrdata <= VERSION_ID;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ===== test/wwd_top_sva.sv
`timescale 1ns/1ps
module wwd_chk #(
  parameter SLEEP_W = 3,
  parameter [SLEEP_W-1:0] RC_DEEPEST = 3'h4
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [SLEEP_W-1:0] sleep_req,
  input wire [SLEEP_W-1:0] sleep_grant,
  input wire watchdog_reset,
  input wire calibration_start
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_at(logic [9:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[9:0] == a;
  endsequence
  sequence boot_seen;
    $rose(hresetn);
  endsequence
  a_key_reads_zero: assert property (rd_at(10'h000) |=> hrdata[31:24] == 8'h00)
    else $error("control key field read back nonzero");
  a_status_spare: assert property (rd_at(10'h008) |=> hrdata[31:2] == 30'h0)
    else $error("status spare bits nonzero");
  a_no_wait: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_reset_pulse: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  a_cal_pulse: assert property (calibration_start |=> !calibration_start)
    else $error("calibration start longer than one cycle");
  a_cal_boot: assert property (boot_seen |-> ##[1:12] calibration_start)
    else $error("no calibration after reset");
  a_sleep_cap: assert property (sleep_grant <= sleep_req)
    else $error("granted sleep deeper than asked");
  a_sleep_floor: assert property
    (sleep_grant >= ((sleep_req < RC_DEEPEST) ? sleep_req : RC_DEEPEST))
    else $error("granted sleep too shallow");
endmodule
bind wwd_top wwd_chk #(.SLEEP_W(SLEEP_W), .RC_DEEPEST(RC_DEEPEST)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sleep_req(sleep_req), .sleep_grant(sleep_grant),
  .watchdog_reset(watchdog_reset), .calibration_start(calibration_start));

// ===== test/windowed_watchdog_timer_test.sv
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg dbg = 0, rid = 0, pde = 0, rc = 0, xt = 0, fuse = 0, cdone = 0;
  reg [31:0] haddr = 0, hwdata = 0, r;
  reg [1:0] htrans = 0;
  reg [2:0] sreq = 3'h7;
  reg [7:0] div = 0;
  reg [47:0] rows [0:16];
  wire hready, hresp, wdr, cstart;
  wire [31:0] hrdata;
  wire [2:0] sgrant;
  integer miscompares = 0, n_tests = 0, i, t, nw = 0, t0;
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    div <= div + 8'h01;
    rc <= div[2];
    xt <= div[4];
    if (wdr === 1'b1)
      nw <= nw + 1;
  end
  // arbitrary identification value
  wwd_top #(.VERSION_ID(32'h0000c0de)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .system_rc_osc(rc), .crystal_32k_osc(xt), .auto_enable_fuse(fuse),
    .calibration_done(cdone), .debug_halt(dbg), .run_in_debug(rid),
    .peripheral_debug_en(pde), .sleep_req(sreq), .sleep_grant(sgrant),
    .watchdog_reset(wdr), .calibration_start(cstart));
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task cmp(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
    end
  endtask
  task key(input [31:0] a, input [31:0] d);
    begin
      xfer(1'b1, a, {8'h55, d[23:0]});
      xfer(1'b1, a, {8'haa, d[23:0]});
    end
  endtask
  task rdc(input [31:0] a, input [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      cmp("register read", e, r);
    end
  endtask
  task wdr_in(input integer lo, input integer hi);
    begin
      t = 0;
      while (wdr === 1'b1) @(posedge hclk);
      while (wdr !== 1'b1 && t <= hi) begin
        @(posedge hclk);
        t = t + 1;
      end
      cmp("reset delay in range", 32'h1, (t >= lo && t <= hi));
    end
  endtask
  initial begin
    #300000;
    miscompares = miscompares + 1;
    summarize;
  end
  initial begin
    rows[0] = 48'h0_000_00010000;
    rows[1] = 48'h0_008_00000003;
    rows[2] = 48'h0_3fc_0000c0de;
    rows[3] = 48'h0_010_00000000;
    rows[4] = 48'h1_000_55010100;
    rows[5] = 48'h1_000_aa010100;
    rows[6] = 48'h0_000_00010100;
    rows[7] = 48'h1_000_55010204;
    rows[8] = 48'h1_000_aa010304;
    rows[9] = 48'h0_000_00010100;
    rows[10] = 48'h1_000_55010204;
    rows[11] = 48'h1_000_11010204;
    rows[12] = 48'h1_000_aa010204;
    rows[13] = 48'h0_000_00010100;
    rows[14] = 48'h1_000_55010204;
    rows[15] = 48'h1_000_aa010204;
    rows[16] = 48'h0_000_00010204;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (i = 0; i < 17; i = i + 1) begin
      xfer(rows[i][44], {20'h0, rows[i][43:32]}, rows[i][31:0]);
      if (rows[i][44] === 1'b0)
        cmp("row read", rows[i][31:0], r);
    end
    key(0, 32'h00010101);
    repeat (12) @(posedge hclk);
    cmp("sleep grant rc", 32'h4, sgrant);
    wdr_in(4, 60);
    wdr_in(24, 44);
    rdc(0, 32'h00010101);
    dbg <= 1'b1;
    t0 = nw;
    repeat (100) @(posedge hclk);
    cmp("frozen resets", t0, nw);
    rid <= 1'b1;
    pde <= 1'b1;
    wdr_in(0, 60);
    dbg <= 1'b0;
    key(0, 32'h00010401);
    t0 = nw;
    repeat (3) begin
      repeat (120) @(posedge hclk);
      key(4, 32'h1);
    end
    repeat (8) @(posedge hclk);
    rdc(8, 32'h3);
    cmp("cleared resets", t0, nw);
    repeat (120) @(posedge hclk);
    xfer(1'b1, 4, 32'h55000001);
    xfer(1'b1, 4, 32'haa000000);
    wdr_in(80, 150);
    key(0, 32'h00010405);
    rdc(0, 32'h00010401);
    key(0, 32'h00010400);
    repeat (20) @(posedge hclk);
    key(0, 32'h00050105);
    repeat (12) @(posedge hclk);
    rdc(8, 32'h2);
    key(4, 32'h1);
    wdr_in(0, 12);
    wdr_in(48, 80);
    key(0, 32'h00050107);
    wdr_in(40, 90);
    repeat (20) @(posedge hclk);
    rdc(0, 32'h00050106);
    cdone <= 1'b1;
    @(posedge hclk);
    cdone <= 1'b0;
    rdc(0, 32'h00050186);
    key(0, 32'h0005018e);
    key(0, 32'h00010000);
    rdc(0, 32'h0005018e);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc(0, 32'h00010000);
    cmp("sleep grant off", 32'h7, sgrant);
    key(0, 32'h00000000);
    repeat (40) @(posedge hclk);
    rdc(0, 32'h00000000);
    key(0, 32'h00020000);
    key(0, 32'h00030001);
    repeat (80) @(posedge hclk);
    cmp("sleep grant xtal", 32'h6, sgrant);
    rdc(0, 32'h00030001);
    fuse <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (20) @(posedge hclk);
    rdc(0, 32'h00011001);
    key(0, 32'h00011003);
    rdc(0, 32'h00011001);
    summarize;
  end
endmodule
